// [hw/rrcm_connection_monitor.sv]
// Purpose: per-connection receive monitor for RTP/UDP voice packets
// Assumes: packet fields and local time come from logic on clk
// Notes:   zero-wait APB slave; events and dispatch use valid/ready
`timescale 1ns/10ps
module rrcm_connection_monitor (
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        pktValid,
    output logic             pktReady,
    input  wire logic [15:0] pktUdpLen,
    input  wire logic        pktCsumBad,
    input  wire logic        pktMarker,
    input  wire logic [6:0]  pktPayloadType,
    input  wire logic [15:0] pktSeq,
    input  wire logic [31:0] pktRtpTs,
    input  wire logic [23:0] tdmTime,
    output logic      [31:0] tblAddr,
    output logic             evtValid,
    input  wire logic        evtReady,
    output logic      [3:0]  evtFlags,
    output logic      [15:0] evtPrevSeq,
    output logic      [15:0] evtCurSeq,
    output logic      [7:0]  evtTag,
    output logic      [23:0] evtTime,
    output logic             chanValid,
    input  wire logic        chanReady,
    output logic      [31:0] chanAddr,
    output logic      [2:0]  chanType,
    output logic      [3:0]  chanSel
);
    typedef struct packed {
        rrcm_pkg::rrcm_state_t fsm;
        logic                  discardEn;
        logic                  csReportEn;
        logic                  rtpFormat;
        logic                  lossEn;
        logic                  jitStarted;
        logic                  initDone;
        logic [24:0]           tblBase;
        logic [15:0][31:0]     chanEntry;
        logic [255:0][3:0]     selTbl;
        logic [15:0]           lastSeq;
        logic [31:0]           lastTs;
        logic [23:0]           lastLocal;
        logic [31:0]           jitter;
        logic [15:0]           pktCount;
        logic [31:0]           octets;
        logic [31:0]           rdata;
        logic                  slvErr;
        logic                  pMarker;
        logic [6:0]            pPt;
        logic [15:0]           pLen;
        logic                  pCsum;
        logic [15:0]           pSeq;
        logic [31:0]           pTs;
        logic [23:0]           pNow;
        logic [7:0]            idx;
        logic [31:0]           entry;
        logic                  pDisp;
        logic [31:0]           tblAddr;
        logic                  evtValid;
        logic [3:0]            evtFlags;
        logic [15:0]           evtPrevSeq;
        logic [15:0]           evtCurSeq;
        logic [7:0]            evtTag;
        logic [23:0]           evtTime;
        logic                  chanValid;
        logic [31:0]           chanAddr;
        logic [2:0]            chanType;
        logic [3:0]            chanSel;
    } rrcm_state_s_t;

    rrcm_state_s_t q;
    rrcm_state_s_t next_q;

    // UDP payload length, floored at zero for runt headers
    function automatic logic [15:0] payloadLen(input logic [15:0] len);
        payloadLen = (len < rrcm_pkg::UDP_HDR) ? 16'h0000
                                               : len - rrcm_pkg::UDP_HDR;
    endfunction

    // scaled jitter step: j holds the estimate times sixteen
    function automatic logic [31:0] jitterStep(input logic [31:0] j,
                                               input logic [23:0] arr,
                                               input logic [31:0] ts);
        logic [23:0] d;
        logic [23:0] absD;
        d    = arr - ts[23:0];
        absD = d[23] ? (24'h000000 - d) : d;
        jitterStep = j + {8'h00, absD} - (j >> rrcm_pkg::FRAC_BITS);
    endfunction

    logic        apbSetup;
    logic        apbWrite;
    logic        drop;
    logic [15:0] curPayLen;
    logic [2:0]  entType;
    logic        entIj;
    logic        entReport;
    logic        lossSeen;

    assign apbSetup  = psel && !penable;
    assign apbWrite  = psel && penable && pwrite;
    assign curPayLen = payloadLen(q.pLen);
    assign drop      = q.pCsum && q.discardEn;
    assign entType   = q.entry[rrcm_pkg::CH_TYPE_LSB +: 3];
    assign entIj     = q.entry[rrcm_pkg::CH_IJ];
    assign entReport = q.entry[rrcm_pkg::CH_REPORT];
    // sequence gap, only once a previous packet exists
    assign lossSeen  = q.lossEn && q.rtpFormat && q.initDone
                       && (q.pSeq != q.lastSeq + 16'h0001);

    // next state: bus access first, so hardware sets below win
    always_comb begin
        next_q = q;
        // read data and error are captured in the setup cycle
        if (apbSetup) begin
            next_q.slvErr = 1'b0;
            next_q.rdata  = 32'h00000000;
            if (paddr[11:10] == rrcm_pkg::TBL_PAGE) begin
                next_q.rdata = {28'h0000000, q.selTbl[paddr[9:2]]};
            end else if (paddr[11:6] == rrcm_pkg::CHAN_PAGE) begin
                next_q.rdata = q.chanEntry[paddr[5:2]];
            end else begin
                case (paddr)
                    rrcm_pkg::OFS_CTRL: begin
                        next_q.rdata[rrcm_pkg::CTRL_DISCARD] = q.discardEn;
                        next_q.rdata[rrcm_pkg::CTRL_CSREP]   = q.csReportEn;
                        next_q.rdata[rrcm_pkg::CTRL_RTP]     = q.rtpFormat;
                        next_q.rdata[rrcm_pkg::CTRL_LOSS]    = q.lossEn;
                        next_q.rdata[rrcm_pkg::CTRL_JSTART]  = q.jitStarted;
                        next_q.rdata[rrcm_pkg::CTRL_INIT]    = q.initDone;
                    end
                    rrcm_pkg::OFS_TBLBASE: next_q.rdata = {7'h00, q.tblBase};
                    rrcm_pkg::OFS_LASTSEQ: next_q.rdata = {16'h0000, q.lastSeq};
                    rrcm_pkg::OFS_LASTTS:  next_q.rdata = q.lastTs;
                    rrcm_pkg::OFS_LOCALTS: next_q.rdata = {8'h00, q.lastLocal};
                    rrcm_pkg::OFS_JITTER:  next_q.rdata = q.jitter;
                    rrcm_pkg::OFS_PKTCNT:  next_q.rdata = {16'h0000, q.pktCount};
                    rrcm_pkg::OFS_OCTETS:  next_q.rdata = q.octets;
                    default:               next_q.slvErr = 1'b1;
                endcase
            end
        end
        // writes land only on the access edge; counters are read only
        if (apbWrite) begin
            if (paddr[11:10] == rrcm_pkg::TBL_PAGE) begin
                next_q.selTbl[paddr[9:2]] = pwdata[3:0];
            end else if (paddr[11:6] == rrcm_pkg::CHAN_PAGE) begin
                next_q.chanEntry[paddr[5:2]] = pwdata;
            end else if (paddr == rrcm_pkg::OFS_CTRL) begin
                next_q.discardEn  = pwdata[rrcm_pkg::CTRL_DISCARD];
                next_q.csReportEn = pwdata[rrcm_pkg::CTRL_CSREP];
                next_q.rtpFormat  = pwdata[rrcm_pkg::CTRL_RTP];
                next_q.lossEn     = pwdata[rrcm_pkg::CTRL_LOSS];
                next_q.jitStarted = pwdata[rrcm_pkg::CTRL_JSTART];
                next_q.initDone   = pwdata[rrcm_pkg::CTRL_INIT];
            end else if (paddr == rrcm_pkg::OFS_TBLBASE) begin
                next_q.tblBase = pwdata[24:0];
            end
        end
        case (q.fsm)
            rrcm_pkg::ST_IDLE: begin
                if (pktValid) begin
                    next_q.pMarker = pktMarker;
                    next_q.pPt     = pktPayloadType;
                    next_q.pLen    = pktUdpLen;
                    next_q.pCsum   = pktCsumBad;
                    next_q.pSeq    = pktSeq;
                    next_q.pTs     = pktRtpTs;
                    next_q.pNow    = tdmTime;
                    next_q.fsm     = rrcm_pkg::ST_LOOKUP;
                end
            end
            rrcm_pkg::ST_LOOKUP: begin
                if (q.rtpFormat) begin
                    next_q.idx = {q.pMarker, q.pPt};
                end else if (curPayLen > {8'h00, rrcm_pkg::IDX_CAP}) begin
                    next_q.idx = rrcm_pkg::IDX_CAP;
                end else begin
                    next_q.idx = curPayLen[7:0];
                end
                next_q.fsm = rrcm_pkg::ST_UPDATE;
            end
            rrcm_pkg::ST_UPDATE: begin
                // lookup entry byte address, two entries per byte
                next_q.tblAddr = ({7'h00, q.tblBase} << rrcm_pkg::TBL_SHIFT)
                                 + {25'h0000000, q.idx[7:1]};
                next_q.entry   = q.chanEntry[q.selTbl[q.idx]];
                next_q.chanSel = q.selTbl[q.idx];
                next_q.evtFlags   = 4'h0;
                next_q.evtPrevSeq = q.lastSeq;
                next_q.evtCurSeq  = q.pSeq;
                next_q.evtTag     = q.idx;
                next_q.evtTime    = q.pNow;
                // checksum report, also for dropped packets
                next_q.evtFlags[rrcm_pkg::EVT_CS] = q.pCsum && q.csReportEn;
                next_q.pDisp = 1'b0;
                next_q.fsm   = rrcm_pkg::ST_EVENT;
            end
            rrcm_pkg::ST_EVENT: begin
                // first pass: apply updates; entry now holds the split
                if (!q.evtValid && !q.chanValid) begin
                    if (!drop) begin
                        next_q.pktCount = q.pktCount + 16'h0001;
                        next_q.octets = q.octets + {16'h0000, curPayLen};
                        next_q.initDone = 1'b1;
                        next_q.evtFlags[rrcm_pkg::EVT_INIT] = !q.initDone;
                        next_q.evtFlags[rrcm_pkg::EVT_LOSS] = lossSeen;
                        next_q.evtFlags[rrcm_pkg::EVT_REPORT] = entReport;
                        if (entIj) begin
                            next_q.lastSeq   = q.pSeq;
                            next_q.lastTs    = q.pTs;
                            next_q.lastLocal = q.pNow;
                            next_q.jitStarted = 1'b1;
                            if (q.jitStarted) begin
                                next_q.jitter = jitterStep(q.jitter,
                                    q.pNow - q.lastLocal, q.pTs - q.lastTs);
                            end
                        end
                        // delete and reserved types dispatch nothing
                        case (entType)
                            rrcm_pkg::TYPE_PCM,
                            rrcm_pkg::TYPE_HDLC,
                            rrcm_pkg::TYPE_CPU: next_q.pDisp = 1'b1;
                            default:            next_q.pDisp = 1'b0;
                        endcase
                    end
                    next_q.chanAddr = {16'h0000,
                        q.entry[rrcm_pkg::CH_ADDR_MSB:0]}
                        << rrcm_pkg::CHAN_SHIFT;
                    next_q.chanType = entType;
                    next_q.fsm      = rrcm_pkg::ST_DISPATCH;
                end
            end
            rrcm_pkg::ST_DISPATCH: begin
                // event to queue writer, then channel hand-off
                if (q.evtValid) begin
                    if (evtReady) begin
                        next_q.evtValid  = 1'b0;
                        next_q.chanValid = q.pDisp;
                        if (!q.pDisp) begin
                            next_q.fsm = rrcm_pkg::ST_IDLE;
                        end
                    end
                end else if (q.chanValid) begin
                    if (chanReady) begin
                        next_q.chanValid = 1'b0;
                        next_q.fsm       = rrcm_pkg::ST_IDLE;
                    end
                end else if (q.evtFlags != 4'h0) begin
                    next_q.evtValid = 1'b1;
                end else if (q.pDisp) begin
                    next_q.chanValid = 1'b1;
                end else begin
                    next_q.fsm = rrcm_pkg::ST_IDLE;
                end
            end
            default: next_q.fsm = rrcm_pkg::ST_IDLE;
        endcase
    end

    // all state resets to zero; software programs the structure
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign prdata     = q.rdata;
    assign pready     = 1'b1;
    assign pslverr    = q.slvErr;
    assign pktReady   = (q.fsm == rrcm_pkg::ST_IDLE);
    assign tblAddr    = q.tblAddr;
    assign evtValid   = q.evtValid;
    assign evtFlags   = q.evtFlags;
    assign evtPrevSeq = q.evtPrevSeq;
    assign evtCurSeq  = q.evtCurSeq;
    assign evtTag     = q.evtTag;
    assign evtTime    = q.evtTime;
    assign chanValid  = q.chanValid;
    assign chanAddr   = q.chanAddr;
    assign chanType   = q.chanType;
    assign chanSel    = q.chanSel;

    // checks on the update pass
    logic applyStep;
    assign applyStep = (q.fsm == rrcm_pkg::ST_EVENT)
                       && !q.evtValid && !q.chanValid;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    property p_count;
        applyStep && !drop |=> q.pktCount == $past(q.pktCount) + 16'h0001;
    endproperty
    a_count: assert property (p_count) else $error("packet count");
    property p_octets;
        applyStep && !drop |=>
            q.octets == $past(q.octets) + {16'h0000, $past(curPayLen)};
    endproperty
    a_octets: assert property (p_octets) else $error("octet count");
    property p_discard;
        applyStep && drop |=> $stable(q.pktCount) && $stable(q.lastTs)
            && $stable(q.initDone) && !q.chanValid;
    endproperty
    a_discard: assert property (p_discard) else $error("discard");
    property p_noinc;
        applyStep && !entIj |=> $stable(q.jitter) && $stable(q.lastTs)
            && $stable(q.lastLocal);
    endproperty
    a_noinc: assert property (p_noinc) else $error("jitter moved");
    property p_local;
        applyStep && !drop && entIj |=> q.lastLocal == $past(q.pNow)
            && q.jitStarted;
    endproperty
    a_local: assert property (p_local) else $error("local stamp");
    property p_csrep;
        (q.fsm == rrcm_pkg::ST_UPDATE) && q.pCsum && q.csReportEn
            ##1 1'b1 [*1] ##1 1'b1 |-> ##[0:2] q.evtValid;
    endproperty
    a_csrep: assert property (p_csrep) else $error("no cs event");
    property p_delete;
        applyStep && entType == rrcm_pkg::TYPE_DELETE |=>
            (!q.chanValid) [*3];
    endproperty
    a_delete: assert property (p_delete) else $error("delete sent");

    property p_cap;
        (q.fsm == rrcm_pkg::ST_LOOKUP) && !q.rtpFormat
            && curPayLen > 16'h00FF |=> q.idx == rrcm_pkg::IDX_CAP;
    endproperty
    a_cap: assert property (p_cap) else $error("index cap");

    property p_evthold;
        q.evtValid && !evtReady |=> q.evtValid && $stable(q.evtFlags);
    endproperty
    a_evthold: assert property (p_evthold) else $error("event drop");

    c_event:   cover property (q.evtValid && evtReady);
    c_dispatch: cover property (q.chanValid && chanReady);
    c_jitter:  cover property (applyStep && entIj && q.jitStarted);
endmodule

// [hw/rrcm_pkg.sv]
// Purpose: constants for the receive RTP connection monitor
// Assumes: 32-bit APB, one connection structure held in flip-flops
// Notes:   byte offsets of the APB register map and field layouts
//
// What this block does
// - jitter uses RTP timestamp delta and local arrival time delta
// - jitter becomes 15/16 old plus 1/16 new delay variation
// - include flag low leaves jitter and both timestamps untouched
// - every packet not discarded counts in 16-bit packets, 32-bit octets
// - octet count grows by UDP length minus eight
// - lookup result selects channel structure address, which is issued
// - delete type reads no channel structure and drops the packet
// - type codes: 000 PCM, 001 HDLC, 010 CPU, 111 delete
// - lookup address is base pointer in 128-byte units plus index over two
// - bad checksum with discard set drops before any field changes
// - RTP format indexes by marker and payload type, else length
// - checksum report set posts an event for each bad checksum
// - loss report set posts an event on sequence gaps in RTP format
// - jitter started flag set by first packet with include flag
// - software clears initialized flag; first packet sets it
// - low 24 bits of local time stored as last local timestamp
// - jitter estimate is kept in 1/16 TDM frame units
// - last received sequence number is stored
// - include flag packets update sequence, RTP timestamp, jitter
// - entry report flag posts a report event for the packet
// - events are handed to the circular queue writer
// - UDP-only index is capped at 255
// - 256 lookup entries each hold a 4-bit selector
package rrcm_pkg;
    localparam logic [11:0] OFS_CTRL    = 12'h000;
    localparam logic [11:0] OFS_TBLBASE = 12'h004;
    localparam logic [11:0] OFS_LASTSEQ = 12'h008;
    localparam logic [11:0] OFS_LASTTS  = 12'h00C;
    localparam logic [11:0] OFS_LOCALTS = 12'h010;
    localparam logic [11:0] OFS_JITTER  = 12'h014;
    localparam logic [11:0] OFS_PKTCNT  = 12'h018;
    localparam logic [11:0] OFS_OCTETS  = 12'h01C;
    localparam logic [5:0]  CHAN_PAGE   = 6'h01;  // 0x040..0x07C
    localparam logic [1:0]  TBL_PAGE    = 2'h1;   // 0x400..0x7FC
    localparam int CTRL_DISCARD = 0;
    localparam int CTRL_CSREP   = 1;
    localparam int CTRL_RTP     = 2;
    localparam int CTRL_LOSS    = 3;
    localparam int CTRL_JSTART  = 4;
    localparam int CTRL_INIT    = 5;
    localparam int CH_ADDR_MSB  = 15;
    localparam int CH_TYPE_LSB  = 16;
    localparam int CH_IJ        = 19;
    localparam int CH_REPORT    = 20;
    localparam int EVT_CS       = 0;
    localparam int EVT_REPORT   = 1;
    localparam int EVT_LOSS     = 2;
    localparam int EVT_INIT     = 3;
    localparam logic [2:0]  TYPE_PCM    = 3'h0;
    localparam logic [2:0]  TYPE_HDLC   = 3'h1;
    localparam logic [2:0]  TYPE_CPU    = 3'h2;
    localparam logic [2:0]  TYPE_DELETE = 3'h7;
    localparam logic [15:0] UDP_HDR     = 16'h0008;
    localparam logic [7:0]  IDX_CAP     = 8'hFF;
    localparam int FRAC_BITS  = 4;
    localparam int TBL_SHIFT  = 7;
    localparam int CHAN_SHIFT = 5;
    typedef enum logic [2:0] {
        ST_IDLE, ST_LOOKUP, ST_UPDATE, ST_EVENT, ST_DISPATCH
    } rrcm_state_t;
endpackage

// [tb/rrcm_upstream_model.sv]
// Purpose: upstream lookup logic model that offers packets
// Assumes: an offer is held until the monitor takes it
// Notes:   released fields show the inverse value, never the last one
`timescale 1ns/10ps
module rrcm_upstream_model (
    input  wire logic        clk,
    input  wire logic        pktReady,
    output logic             pktValid,
    output logic      [72:0] pktBits
);
    initial pktValid = 1'b0;
    initial pktBits = '0;
    // hold the offer until an edge that sees ready high
    task automatic offer(input logic [72:0] f, output bit ok);
        bit r;
        r = 1'b0;
        @(posedge clk);
        pktValid <= 1'b1;
        pktBits <= f;
        for (int i = 0; i < 64 && !r; i++) begin
            @(posedge clk);
            r = pktReady;
        end
        ok = r;
        pktValid <= 1'b0;
        pktBits <= ~f;  // stale fields would hide a late capture
    endtask
endmodule

// [tb/rx_rtp_connection_monitor_test.sv]
// Purpose: self-checking bench for the connection monitor
// Assumes: zero-wait APB slave, one packet in flight at a time
// Notes:   random packets from a fixed xorshift seed
`timescale 1ns/10ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    err_total++; $display("unexpected %0t: got %h want %h", \
    $time, a, b); end end
module rx_rtp_connection_monitor_test;
    logic        clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, tblAddr, chanAddr, q;
    logic [31:0] seed = 32'h000103A4, ctl = '0, base = '0, r;
    logic [31:0] lastRts = '0, jit = '0, oct = '0, pktRtpTs;
    logic        pready, pslverr, pktValid, pktReady, pktCsumBad, e;
    logic        pktMarker, evtValid, chanValid, evtReady = 0;
    logic        chanReady = 0, jStart = 0, init = 0;
    logic [72:0] pktBits;
    logic [15:0] pktUdpLen, pktSeq, evtPrevSeq, evtCurSeq;
    logic [15:0] lastSeq = '0, cnt = '0;
    logic [23:0] tdmTime = '0, evtTime, lastLoc = '0;
    logic [6:0]  pktPayloadType;
    logic [3:0]  evtFlags, chanSel;
    logic [7:0]  evtTag;
    logic [2:0]  chanType;
    int          err_total = 0, tests_run = 0;
    rrcm_connection_monitor rrcm_connection_monitor_i (.clk, .rstn, .psel,
        .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .pktValid, .pktReady, .pktUdpLen, .pktCsumBad, .pktMarker,
        .pktPayloadType, .pktSeq, .pktRtpTs, .tdmTime, .tblAddr,
        .evtValid, .evtReady, .evtFlags, .evtPrevSeq, .evtCurSeq, .evtTag,
        .evtTime, .chanValid, .chanReady, .chanAddr, .chanType, .chanSel);
    rrcm_upstream_model rrcm_upstream_model_i (.clk, .pktReady, .pktValid,
        .pktBits);
    assign {pktUdpLen, pktCsumBad, pktMarker, pktPayloadType, pktSeq,
        pktRtpTs} = pktBits;
    // free-running core clock
    always #12.5 clk = ~clk;
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // entry n: report, include, type, address; covers every type code
    function automatic logic [31:0] ent(input logic [3:0] n);
        return {11'h000, n[3] & n[0], ~n[3], n[2:0], 12'h000, n};
    endfunction
    function automatic logic [3:0] tbl(input logic [7:0] i);
        return i[3:0] ^ i[7:4];
    endfunction
    task automatic test_done();
        $display("errors %0d checks %0d", err_total, tests_run);
        if (err_total == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic lost();
        err_total++;
        $display("unexpected %0t: wait ran out", $time);
        test_done();
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        bit ok;
        ok = 1'b0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && !ok; i++) begin
            @(posedge clk);
            ok = pready;
            q = prdata;
            e = pslverr;
        end
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) lost();
    endtask
    // compare the whole status block with the model
    task automatic regs();
        logic [31:0] x [8];
        x = '{ctl | {26'h0, init, jStart, 4'h0}, base, {16'h0, lastSeq},
              lastRts, {8'h0, lastLoc}, jit, {16'h0, cnt}, oct};
        for (int i = 0; i < 8; i++) begin
            apb(1'b0, 12'(4 * i), '0);
            `CHK(q, x[i])
        end
    endtask
    task automatic seen(input bit ch);
        bit v;
        v = 1'b0;
        for (int i = 0; i < 32 && !v; i++) begin
            @(negedge clk);
            v = ch ? chanValid : evtValid;
        end
        if (!v) lost();
    endtask
    // ready comes late at random so held outputs are exercised
    task automatic ack(input bit ch);
        repeat (rnd() % 3) @(posedge clk);
        @(posedge clk);
        if (ch) chanReady <= 1'b1; else evtReady <= 1'b1;
        @(posedge clk);
        if (ch) chanReady <= 1'b0; else evtReady <= 1'b0;
    endtask
    task automatic pkt(input logic [15:0] len, input logic bad,
                       input logic [7:0] mpt, input logic [15:0] sq);
        logic [31:0] ts, en, rr;
        logic [15:0] pay, ps;
        logic [23:0] t, d;
        logic [67:0] w;
        logic [7:0]  idx;
        logic [3:0]  fl;
        logic        drop;
        bit          ok;
        rr = rnd();
        ts = lastRts + {24'h0, rr[7:0]};
        t = tdmTime + {16'h0, rr[15:8]};
        ps = lastSeq;
        pay = len < 16'h0008 ? 16'h0000 : len - 16'h0008;
        idx = ctl[2] ? mpt : (pay > 16'h00FF ? 8'hFF : pay[7:0]);
        en = ent(tbl(idx));
        drop = bad & ctl[0];
        fl = {~drop & ~init, ~drop & ctl[2] & ctl[3] & init &
              (sq != lastSeq + 16'h0001), ~drop & en[20], bad & ctl[1]};
        @(posedge clk);
        tdmTime <= t;
        rrcm_upstream_model_i.offer({len, bad, mpt, sq, ts}, ok);
        if (!ok) lost();
        if (!drop) begin
            cnt++;
            oct = oct + {16'h0, pay};
            if (en[19]) begin
                d = (t - lastLoc) - (ts[23:0] - lastRts[23:0]);
                d = d[23] ? -d : d;
                if (jStart) jit = jit + {8'h0, d} - (jit >> 4);
                lastSeq = sq;
                lastRts = ts;
                lastLoc = t;
                jStart = 1'b1;
            end
            init = 1'b1;
        end
        if (fl != 4'h0) begin
            seen(1'b0);
            w = {fl, ps, sq, idx, t};
            `CHK({evtFlags, evtPrevSeq, evtCurSeq, evtTag, evtTime}, w)
            ack(1'b0);
        end
        if (!drop && en[18:16] inside {3'h0, 3'h1, 3'h2}) begin
            seen(1'b1);
            w = {29'h0, tbl(idx), en[18:16], 11'h0, en[15:0], 5'h00};
            `CHK({chanSel, chanType, chanAddr}, w[38:0])
            ack(1'b1);
        end
        @(negedge clk);
        for (int i = 0; i < 32 && pktReady !== 1'b1; i++) @(negedge clk);
        `CHK({evtValid, chanValid, pktReady}, 3'b001)
        if (!drop) `CHK(tblAddr, (base << 7) + {25'h0, idx[7:1]})
    endtask
    initial begin
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        regs();
        // unmapped read errors; a read-only write is ignored
        apb(1'b0, 12'h020, '0);
        `CHK({e, q}, 33'h1_0000_0000)
        apb(1'b1, 12'h018, 32'h0000_1234);
        apb(1'b0, 12'h018, '0);
        `CHK({e, q}, 33'h0_0000_0000)
        for (int n = 0; n < 16; n++) apb(1'b1, 12'(64 + 4 * n), ent(4'(n)));
        for (int i = 0; i < 256; i++)
            apb(1'b1, 12'(1024 + 4 * i), {28'h0, tbl(8'(i))});
        base = 32'h0000_0123;
        apb(1'b1, 12'h004, base);
        for (int b = 0; b < 2; b++) begin
            // software clears both start flags; loss off without RTP
            ctl = b ? 32'h0000_0002 : 32'h0000_000F;
            apb(1'b1, 12'h000, ctl);
            init = 1'b0;
            jStart = 1'b0;
            for (int k = 0; k < 120; k++) begin
                r = rnd();
                pkt(k < 4 ? 16'(7 + 128 * k) : {7'h0, r[8:0]},
                    r[12:10] == 3'h0, r[20:13],
                    lastSeq + {14'h0, r[23:21] == 3'h0, 1'b1});
            end
            regs();
        end
        test_done();
    end
endmodule
